/* design/ric_startup.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Start-up delay counter, advanced by watchdog oscillator ticks.
module ric_startup
	import ric_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = ric_pkg::STARTUP_SHORT,
	parameter int unsigned LONG_CYCLES = ric_pkg::STARTUP_LONG
) (
	// Clock and reset; reset starts a fresh count.
	input wire logic clk,
	input wire logic rst,
	// Control.
	input wire logic restart,
	input wire logic osc_tick,
	input wire logic short_sel,
	// Core hold.
	output logic hold
);
	ric_state_type state_q, state_d; // Counting or released.
	logic [STARTUP_CNT_W-1:0] cnt_q, cnt_d; // Oscillator ticks seen.
	logic [STARTUP_CNT_W-1:0] last; // Final tick count.

	// Next state: count ticks until the chosen period has passed.
	always_comb
	begin
		last = short_sel ? STARTUP_CNT_W'(SHORT_CYCLES - 1)
			: STARTUP_CNT_W'(LONG_CYCLES - 1);
		state_d = state_q;
		cnt_d = cnt_q;
		if (restart)
		begin
			state_d = ST_COUNT;
			cnt_d = '0;
		end
		else
		begin
			unique case (state_q)
				ST_COUNT:
				begin
					if (osc_tick && cnt_q == last)
						state_d = ST_RUN;
					else if (osc_tick)
						cnt_d = cnt_q + 1'b1;
				end
				ST_RUN:
				begin
					cnt_d = '0;
				end
			endcase
		end
	end

	// Registers; reset always begins a new delay.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ST_COUNT;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign hold = (state_q == ST_COUNT);
endmodule
`default_nettype wire

/* design/ric_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Two flip-flop synchroniser for a group of level inputs.
module ric_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Asynchronous inputs and their synchronised copies.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q; // First stage, read only by the second.

	// Both stages load the same constant under reset.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* design/ric_top.sv */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: Pin low resets device, even without clock.
// R02: Reset loads registers, core starts at zero.
// R03: Delay lasts 1K or 16K oscillator cycles.
// R04: Delay counts from the reset pin release.
// R05: Outside party may stretch power-on reset.
// R06: Watchdog pulse one cycle, then delay starts.
// R07: Pin cause bit set by pin reset only.
// R08: Power-on cause bit set by power-on only.
// R09: Software reads then clears both cause bits.
// R10: Accepting an interrupt clears global enable.
// R11: Return from interrupt sets global enable.
// R12: Vectoring clears the taken source's flag.
// R13: Masked condition still sets its flag.
// R14: Pending flags wait, then serve by priority.
// R15: Lower vector wins; request zero before one.
// R16: Level request has no flag, pin only.
// R17: Handler software saves the status word.
// R18: Mask bit 7 enables request one.
// R19: Mask bit 6 enables request zero.
// R20: Sense bits pick rising, falling or level.
// R21: Pin activity counts even as output.
// R22: Flags set by edges, zero in level.
// R23: Edge flag clears on entry or one.
// R24: Reserved bits always read zero.
// R25: Pins synchronised before edge detection.
// =====================================================================
// Reset sequencing and external interrupt acceptance.
module ric_top
	import ric_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = ric_pkg::STARTUP_SHORT,
	parameter int unsigned LONG_CYCLES = ric_pkg::STARTUP_LONG
) (
	// Clock and power-on reset.
	input wire logic CORE_CLK,
	input wire logic RESET,
	// External reset pin, active low.
	input wire logic RESET_PIN_N,
	// Watchdog side.
	input wire logic WDT_OSC,
	input wire logic WDT_ENABLE,
	input wire logic WDT_TIMEOUT,
	input wire logic STARTUP_TIME_SELECT,
	// External request pins.
	input wire logic EXT_REQUEST_ZERO,
	input wire logic EXT_REQUEST_ONE,
	// Core handshake.
	input wire logic IRQ_ACCEPT,
	input wire logic RETURN_FROM_INTERRUPT,
	output logic CORE_RESET,
	output logic IRQ_PENDING,
	output logic [ric_pkg::VEC_W-1:0] IRQ_VECTOR,
	output logic GLOBAL_ENABLE,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ric_pkg::ADDR_W-1:0] PADDR,
	input wire logic [ric_pkg::DATA_W-1:0] PWDATA,
	output logic [ric_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);

	// =================================================================
	// Functions.

	// Returns one when the synchronised pin shows a qualifying edge.
	function automatic logic edge_hit(input logic [1:0] mode,
		input logic now, input logic was);
		logic hit;
		hit = 1'b0;
		unique case (ric_sense_type'(mode))
			SENSE_LEVEL: hit = 1'b0;
			SENSE_CHANGE: hit = now ^ was;
			SENSE_FALL: hit = was & ~now;
			SENSE_RISE: hit = now & ~was;
		endcase
		return hit;
	endfunction

	// Returns one when the address matches a mapped register.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_CAUSE) || (a == OFS_MASK) || (a == OFS_FLAGS)
			|| (a == OFS_CTRL) || (a == OFS_STATUS);
	endfunction

	// =================================================================
	// Reset sources.

	logic sys_rst; // Power-on or pin reset, asynchronous.
	logic pin_s; // Synchronised reset pin level.
	logic [2:0] in_s; // Synchronised osc, request one, request zero.
	logic osc_prev_q, osc_prev_d; // Oscillator level of the last cycle.
	logic osc_tick; // One cycle per oscillator rising edge.
	logic wdt_pulse_q, wdt_pulse_d; // One-cycle watchdog reset pulse.
	logic hold; // Start-up delay still running.

	// The pin reaches the reset tree with no clock at all.
	assign sys_rst = RESET | ~RESET_PIN_N; // [R01] [R05]

	// Pin level for the cause bit; only power-on resets this copy.
	ric_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1)
	) u_pin_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.d(RESET_PIN_N),
		.q(pin_s)
	);

	// Oscillator and request pins, read whatever the pin direction.
	ric_sync #(
		.WIDTH(3),
		.RESET_VAL(3'b011)
	) u_in_sync (
		.clk(CORE_CLK),
		.rst(sys_rst),
		.d({WDT_OSC, EXT_REQUEST_ONE, EXT_REQUEST_ZERO}), // [R21] [R25]
		.q(in_s)
	);

	// Tick once per oscillator rising edge; watchdog pulse lasts one cycle.
	always_comb
	begin
		osc_prev_d = in_s[2];
		wdt_pulse_d = WDT_TIMEOUT & WDT_ENABLE & ~wdt_pulse_q; // [R06]
	end

	// Registers for the oscillator edge and the watchdog pulse.
	always_ff @(posedge CORE_CLK or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			osc_prev_q <= 1'b0;
			wdt_pulse_q <= 1'b0;
		end
		else
		begin
			osc_prev_q <= osc_prev_d;
			wdt_pulse_q <= wdt_pulse_d;
		end
	end

	assign osc_tick = in_s[2] & ~osc_prev_q;

	// Delay restarts from the pin release and after a watchdog pulse.
	ric_startup #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) u_startup (
		.clk(CORE_CLK),
		.rst(sys_rst), // [R04]
		.restart(wdt_pulse_q), // [R06]
		.osc_tick(osc_tick),
		.short_sel(STARTUP_TIME_SELECT), // [R03]
		.hold(hold)
	);

	// The core is held through the pulse and the whole delay.
	assign CORE_RESET = sys_rst | hold | wdt_pulse_q; // [R02] [R04]

	// =================================================================
	// Reset cause register.

	logic por_q, por_d; // Power-on cause bit.
	logic ext_q, ext_d; // Pin reset cause bit.
	logic wr_en; // APB write takes effect this edge.
	logic [REG_W-1:0] wbyte; // Low byte of the write data.

	assign wr_en = PSEL & PENABLE & PWRITE;
	assign wbyte = PWDATA[REG_W-1:0];

	// Writing zero clears a bit; a reset event wins over the clear.
	always_comb
	begin
		por_d = por_q;
		ext_d = ext_q;
		if (wr_en && PADDR == OFS_CAUSE)
		begin
			por_d = por_q & wbyte[POWER_ON_CAUSE_BIT]; // [R08]
			ext_d = ext_q & wbyte[PIN_RESET_CAUSE_BIT]; // [R07]
		end
		if (!pin_s)
			ext_d = 1'b1; // [R07]
	end

	// Only power-on resets these bits; other resets leave them alone.
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			por_q <= 1'b1; // [R08]
			ext_q <= 1'b0;
		end
		else
		begin
			por_q <= por_d;
			ext_q <= ext_d;
		end
	end

	// =================================================================
	// Mask, sense control, flags and global enable.

	logic [1:0] mask_q, mask_d; // Enables of request one and zero.
	logic [3:0] ctrl_q, ctrl_d; // Sense pairs of both requests.
	logic [1:0] flag_q, flag_d; // Edge flags of request one and zero.
	logic [1:0] pin_prev_q; // Request pin levels of the last cycle.
	logic [1:0] level_mode; // Request uses low-level sensing.
	logic [1:0] req; // Requests before masking.
	logic [1:0] clr_take; // Flag cleared by vectoring.
	logic gie_q, gie_d; // Global interrupt enable.
	logic take; // Core accepts the offered vector.

	assign take = IRQ_ACCEPT & IRQ_PENDING;

	// Level mode and the request seen by the priority logic.
	always_comb
	begin
		level_mode[0] = ctrl_q[SENSE_ZERO_LSB +: 2] == SENSE_LEVEL;
		level_mode[1] = ctrl_q[SENSE_ONE_LSB +: 2] == SENSE_LEVEL;
		for (int i = 0; i < 2; i++)
			req[i] = level_mode[i] ? ~in_s[i] : flag_q[i]; // [R16]
		clr_take[0] = take && IRQ_VECTOR == EXT_ZERO_VECTOR; // [R12]
		clr_take[1] = take && IRQ_VECTOR == EXT_ONE_VECTOR; // [R12]
	end

	// Next values of the software registers and the flags.
	always_comb
	begin
		mask_d = mask_q;
		ctrl_d = ctrl_q;
		gie_d = gie_q;
		if (wr_en && PADDR == OFS_MASK)
			mask_d = {wbyte[EXT_ONE_BIT], wbyte[EXT_ZERO_BIT]}; // [R18] [R19]
		if (wr_en && PADDR == OFS_CTRL)
			ctrl_d = wbyte[3:0]; // [R20]
		if (wr_en && PADDR == OFS_STATUS)
			gie_d = wbyte[GLOBAL_ENABLE_BIT];
		if (RETURN_FROM_INTERRUPT)
			gie_d = 1'b1; // [R11]
		if (take)
			gie_d = 1'b0; // [R10]
		for (int i = 0; i < 2; i++)
		begin
			// Flags set whatever the mask; the set beats any clear.
			flag_d[i] = flag_q[i] & ~clr_take[i]; // [R13] [R23]
			if (wr_en && PADDR == OFS_FLAGS
				&& wbyte[i == 0 ? EXT_ZERO_BIT : EXT_ONE_BIT])
				flag_d[i] = 1'b0; // [R23]
			if (edge_hit(ctrl_q[2*i +: 2], in_s[i], pin_prev_q[i]))
				flag_d[i] = 1'b1; // [R22]
			if (level_mode[i])
				flag_d[i] = 1'b0; // [R22]
		end
	end

	// Registers; every device reset restores initial values.
	always_ff @(posedge CORE_CLK or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mask_q <= {MASK_RESET[EXT_ONE_BIT], MASK_RESET[EXT_ZERO_BIT]};
			ctrl_q <= CTRL_RESET;
			flag_q <= 2'b00;
			gie_q <= 1'b0;
			pin_prev_q <= 2'b11;
		end
		else if (hold || wdt_pulse_q)
		begin
			// Watchdog reset also restores initial values.
			mask_q <= {MASK_RESET[EXT_ONE_BIT], MASK_RESET[EXT_ZERO_BIT]}; // [R02]
			ctrl_q <= CTRL_RESET;
			flag_q <= 2'b00;
			gie_q <= 1'b0;
			pin_prev_q <= in_s[1:0];
		end
		else
		begin
			mask_q <= mask_d;
			ctrl_q <= ctrl_d;
			flag_q <= flag_d;
			gie_q <= gie_d;
			pin_prev_q <= in_s[1:0];
		end
	end

	assign GLOBAL_ENABLE = gie_q;

	// =================================================================
	// Priority and vector offer.

	logic pend_q, pend_d; // A request is offered to the core.
	logic [VEC_W-1:0] vec_q, vec_d; // Offered program address.

	// Request zero beats request one; reset owns the lowest address.
	always_comb
	begin
		pend_d = 1'b0;
		vec_d = RESET_VECTOR; // [R02]
		if (CORE_RESET)
			vec_d = RESET_VECTOR; // [R15]
		else if (gie_d && mask_q[0] && req[0] && !clr_take[0])
		begin
			pend_d = 1'b1; // [R14] [R19]
			vec_d = EXT_ZERO_VECTOR; // [R15]
		end
		else if (gie_d && mask_q[1] && req[1] && !clr_take[1])
		begin
			pend_d = 1'b1; // [R14] [R18]
			vec_d = EXT_ONE_VECTOR;
		end
	end

	// Offer registers.
	always_ff @(posedge CORE_CLK or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pend_q <= 1'b0;
			vec_q <= RESET_VECTOR;
		end
		else
		begin
			pend_q <= pend_d;
			vec_q <= vec_d;
		end
	end

	assign IRQ_PENDING = pend_q;
	assign IRQ_VECTOR = vec_q;

	// =================================================================
	// APB read path.

	logic [DATA_W-1:0] rdata_q, rdata_d; // Read data for the access phase.
	logic err_q, err_d; // Unmapped address answer.
	logic [REG_W-1:0] rbyte; // Selected register value.

	// Unused and reserved bits read zero.
	always_comb
	begin
		rbyte = '0; // [R24]
		unique case (PADDR)
			OFS_CAUSE:
			begin
				rbyte[POWER_ON_CAUSE_BIT] = por_q;
				rbyte[PIN_RESET_CAUSE_BIT] = ext_q;
			end
			OFS_MASK:
			begin
				rbyte[EXT_ZERO_BIT] = mask_q[0];
				rbyte[EXT_ONE_BIT] = mask_q[1];
			end
			OFS_FLAGS:
			begin
				rbyte[EXT_ZERO_BIT] = flag_q[0]; // [R22]
				rbyte[EXT_ONE_BIT] = flag_q[1];
			end
			OFS_CTRL:
				rbyte[3:0] = ctrl_q;
			OFS_STATUS:
				rbyte[GLOBAL_ENABLE_BIT] = gie_q;
			default:
				rbyte = '0;
		endcase
		rdata_d = rdata_q;
		err_d = err_q;
		// Capture in the setup cycle so the access phase sees a flop.
		if (PSEL && !PENABLE)
		begin
			rdata_d = PWRITE ? '0 : {{(DATA_W-REG_W){1'b0}}, rbyte};
			err_d = !is_mapped(PADDR);
		end
	end

	// Read registers.
	always_ff @(posedge CORE_CLK or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rdata_q <= '0;
			err_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Every access completes in its first access cycle.
	assign PREADY = 1'b1;
	assign PRDATA = rdata_q;
	assign PSLVERR = PSEL & PENABLE & err_q;
endmodule
`default_nettype wire

/* shared/ric_pkg.sv */
// =====================================================================
// Shared constants for the reset and interrupt control block.
package ric_pkg;

	// =================================================================
	// Register bus geometry.
	localparam int unsigned ADDR_W = 8; // Byte address width on APB.
	localparam int unsigned DATA_W = 32; // APB data width.
	localparam int unsigned REG_W = 8; // Width of every register.

	// =================================================================
	// Register byte addresses.
	localparam logic [ADDR_W-1:0] OFS_CAUSE = 8'h00; // reset_cause_status.
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04; // external_request_mask.
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08; // external_request_flags.
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0c; // general_control_register.
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10; // processor_status_word.

	// =================================================================
	// Field positions.
	localparam int unsigned POWER_ON_CAUSE_BIT = 0; // In reset_cause_status.
	localparam int unsigned PIN_RESET_CAUSE_BIT = 1; // In reset_cause_status.
	localparam int unsigned EXT_ZERO_BIT = 6; // Mask and flag of request zero.
	localparam int unsigned EXT_ONE_BIT = 7; // Mask and flag of request one.
	localparam int unsigned SENSE_ZERO_LSB = 0; // Sense pair of request zero.
	localparam int unsigned SENSE_ONE_LSB = 2; // Sense pair of request one.
	localparam int unsigned GLOBAL_ENABLE_BIT = 7; // In processor_status_word.

	// =================================================================
	// Reset values.
	localparam logic [REG_W-1:0] MASK_RESET = 8'h00; // Both requests masked.
	localparam logic [3:0] CTRL_RESET = 4'h0; // Both requests level sensed.

	// =================================================================
	// Program addresses handed to the core.
	localparam int unsigned VEC_W = 12; // Program address width.
	localparam logic [VEC_W-1:0] RESET_VECTOR = 12'h000; // Reset entry.
	localparam logic [VEC_W-1:0] EXT_ZERO_VECTOR = 12'h001; // Request zero.
	localparam logic [VEC_W-1:0] EXT_ONE_VECTOR = 12'h002; // Request one.

	// =================================================================
	// Timing.
	localparam int unsigned PIN_MIN_LOW_NS = 50; // Shortest sure pin reset.
	localparam int unsigned STARTUP_SHORT = 1024; // Oscillator cycles, short.
	localparam int unsigned STARTUP_LONG = 16384; // Oscillator cycles, long.
	localparam int unsigned STARTUP_CNT_W = 15; // Delay counter width.

	// Sense control encoding of one request.
	typedef enum logic [1:0]
	{
		SENSE_LEVEL = 2'b00,
		SENSE_CHANGE = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} ric_sense_type;

	// Start-up delay states.
	typedef enum logic [0:0]
	{
		ST_COUNT = 1'b0,
		ST_RUN = 1'b1
	} ric_state_type;

endpackage

/* tb/ric_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Port-level checks of reset sequencing and interrupt acceptance.
module ric_checker
	import ric_pkg::*;
#(
	parameter int unsigned SHORT_CYCLES = ric_pkg::STARTUP_SHORT,
	parameter int unsigned LONG_CYCLES = ric_pkg::STARTUP_LONG
) (
	// Clock, resets and watchdog.
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic RESET_PIN_N,
	input wire logic WDT_ENABLE,
	input wire logic WDT_TIMEOUT,
	// Core side.
	input wire logic IRQ_ACCEPT,
	input wire logic RETURN_FROM_INTERRUPT,
	input wire logic CORE_RESET,
	input wire logic IRQ_PENDING,
	input wire logic [ric_pkg::VEC_W-1:0] IRQ_VECTOR,
	input wire logic GLOBAL_ENABLE,
	// Register bus.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ric_pkg::DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR
);
	// =================================================================
	// All checks run on the system clock and rest during power-on reset.
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	a_pin_holds_core: assert property (!RESET_PIN_N |-> CORE_RESET)
		else $error("core ran while the reset pin was low");
	a_hold_after_pin: assert property ($rose(RESET_PIN_N) |-> CORE_RESET [*3])
		else $error("core released too soon after the reset pin rose");
	a_wdt_pulse: assert property (WDT_ENABLE && WDT_TIMEOUT && !$past(WDT_TIMEOUT)
		|=> CORE_RESET [*3])
		else $error("watchdog expiry did not hold the core");
	a_wdt_quiet: assert property (!WDT_ENABLE && RESET_PIN_N && !CORE_RESET
		|=> !CORE_RESET || !RESET_PIN_N)
		else $error("core reset with watchdog disabled");
	a_reset_quiet: assert property (CORE_RESET && $past(CORE_RESET)
		|-> !GLOBAL_ENABLE && !IRQ_PENDING && IRQ_VECTOR == RESET_VECTOR)
		else $error("interrupt state not at initial value in reset");
	a_accept_clears: assert property (IRQ_ACCEPT && IRQ_PENDING && !CORE_RESET
		|=> !GLOBAL_ENABLE && !IRQ_PENDING)
		else $error("global enable or pending left set after accept");
	a_return_sets: assert property (RETURN_FROM_INTERRUPT && !IRQ_PENDING && !CORE_RESET
		&& !(PSEL && PENABLE && PWRITE) |=> GLOBAL_ENABLE)
		else $error("return did not set global enable");
	a_pending_needs_gie: assert property (IRQ_PENDING |-> GLOBAL_ENABLE)
		else $error("request offered with global enable clear");
	a_vector_legal: assert property (IRQ_PENDING
		|-> IRQ_VECTOR == EXT_ZERO_VECTOR || IRQ_VECTOR == EXT_ONE_VECTOR)
		else $error("offered vector is not an external request");
	a_upper_zero: assert property (PSEL && PENABLE |-> PREADY && PRDATA[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
endmodule

bind ric_top ric_checker #(.SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) chk_u (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .RESET_PIN_N(RESET_PIN_N),
	.WDT_ENABLE(WDT_ENABLE), .WDT_TIMEOUT(WDT_TIMEOUT), .IRQ_ACCEPT(IRQ_ACCEPT),
	.RETURN_FROM_INTERRUPT(RETURN_FROM_INTERRUPT), .CORE_RESET(CORE_RESET),
	.IRQ_PENDING(IRQ_PENDING), .IRQ_VECTOR(IRQ_VECTOR), .GLOBAL_ENABLE(GLOBAL_ENABLE),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR));
`default_nettype wire

/* tb/ric_pins.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Outside world at the reset and request pins, all pulled up when idle.
module ric_pins (
	// Clock that paces pin changes.
	input wire logic clk,
	// Pins.
	output var logic rst_pin_n,
	output var logic req_zero,
	output var logic req_one
);
	// Pull-ups keep every pin high until driven.
	initial
	begin
		rst_pin_n = 1'b1;
		req_zero = 1'b1;
		req_one = 1'b1;
	end

	// Holds the reset pin low; returns on the edge that releases it.
	task automatic hold_reset(input int cycles);
		@(posedge clk);
		rst_pin_n <= 1'b0;
		repeat (cycles) @(posedge clk);
		rst_pin_n <= 1'b1;
	endtask

	// Drives one request pin to a level.
	task automatic set_req(input logic which, input logic level);
		@(posedge clk);
		if (which)
			req_one <= level;
		else
			req_zero <= level;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Self-checking bench: register calls, pin events and core handshakes.
module tb_top;
	import ric_pkg::*;
	localparam int unsigned SHORT = 4; // Shortened start-up counts.
	localparam int unsigned LONG = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0; // Watchdog oscillator, one tick per 8 clocks.
	logic [1:0] osc_div = 2'h0;
	logic wdt_en = 1'b0;
	logic wdt_to = 1'b0;
	logic short_sel = 1'b0;
	logic accept = 1'b0;
	logic return_from_interrupt = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [DATA_W-1:0] pwdata = 32'h00000000;
	wire logic pin_n, req0, req1, core_rst, pend, gie, pready, pslverr;
	wire logic [VEC_W-1:0] vec;
	wire logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd;
	logic err;
	int n;
	int bad_count = 0;
	int samples_checked = 0;

	ric_pins pins_u (.clk(clk), .rst_pin_n(pin_n), .req_zero(req0), .req_one(req1));
	ric_top #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) dut_u (
		.CORE_CLK(clk), .RESET(rst), .RESET_PIN_N(pin_n), .WDT_OSC(osc),
		.WDT_ENABLE(wdt_en), .WDT_TIMEOUT(wdt_to), .STARTUP_TIME_SELECT(short_sel),
		.EXT_REQUEST_ZERO(req0), .EXT_REQUEST_ONE(req1), .IRQ_ACCEPT(accept),
		.RETURN_FROM_INTERRUPT(return_from_interrupt), .CORE_RESET(core_rst), .IRQ_PENDING(pend),
		.IRQ_VECTOR(vec), .GLOBAL_ENABLE(gie), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr));

	// =================================================================
	// Clock and free-running watchdog oscillator.
	initial
		forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		osc_div <= osc_div + 2'h1;
		if (osc_div == 2'h3)
			osc <= ~osc;
	end

	// =================================================================
	// Shared tasks.
	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; holds the request until pready is seen high.
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k == 20)
			bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string s);
		apb(1'b0, a, 32'h00000000);
		chk(s, e, rd);
	endtask

	// Counts clocks until the core is released.
	task automatic wait_run(output int cyc);
		cyc = 0;
		while (core_rst !== 1'b0 && cyc < 500)
		begin
			@(posedge clk);
			cyc++;
		end
		// A core that never leaves reset is a mismatch.
		if (core_rst !== 1'b0)
			bad_count++;
	endtask

	// Waits for an offered request and checks its vector.
	task automatic wait_pend(input logic [VEC_W-1:0] v);
		int k;
		k = 0;
		while (pend !== 1'b1 && k < 50)
		begin
			@(posedge clk);
			k++;
		end
		// A request that never comes is a mismatch.
		if (pend !== 1'b1)
			bad_count++;
		chk("vector", v, vec);
	endtask

	// Accepts the offered request, then checks the core-side answer.
	task automatic take(input logic [VEC_W-1:0] v);
		wait_pend(v);
		accept <= 1'b1;
		@(posedge clk);
		accept <= 1'b0;
		@(posedge clk);
		chk("gie", 0, gie);
	endtask

	task automatic end_sim();
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// =================================================================
	// Test sequence.
	initial
	begin
		repeat (5) @(posedge clk);
		chk("vector", RESET_VECTOR, vec);
		rst <= 1'b0;
		wait_run(n);
		chk("long delay", 1, n >= (LONG - 1) * 8 && n <= LONG * 8 + 8);
		rchk(OFS_CAUSE, 32'h1, "cause");
		wr(OFS_CAUSE, 32'h0);
		rchk(OFS_CAUSE, 32'h0, "cause");
		wr(OFS_MASK, 32'hff);
		rchk(OFS_MASK, 32'hc0, "mask");
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 1, err);
		chk("unmapped data", 0, rd);
		short_sel <= 1'b1;
		pins_u.hold_reset(6);
		wait_run(n);
		chk("short delay", 1, n >= (SHORT - 1) * 8 && n <= SHORT * 8 + 8);
		rchk(OFS_CAUSE, 32'h2, "cause");
		rchk(OFS_MASK, 32'h0, "mask");
		wdt_en <= 1'b1;
		@(posedge clk);
		wdt_to <= 1'b1;
		@(posedge clk);
		wdt_to <= 1'b0;
		@(posedge clk);
		chk("wdt hold", 1, core_rst);
		wait_run(n);
		rchk(OFS_CAUSE, 32'h2, "cause");
		wr(OFS_STATUS, 32'h80);
		wr(OFS_CTRL, 32'ha);
		pins_u.set_req(1'b0, 1'b0);
		pins_u.set_req(1'b1, 1'b0);
		repeat (6) @(posedge clk);
		rchk(OFS_FLAGS, 32'hc0, "flags");
		chk("pending", 0, pend);
		wr(OFS_MASK, 32'hc0);
		take(EXT_ZERO_VECTOR);
		// The handler saves the status word itself; entry left enable clear.
		rchk(OFS_STATUS, 32'h0, "status");
		rchk(OFS_FLAGS, 32'h80, "flags");
		return_from_interrupt <= 1'b1;
		@(posedge clk);
		return_from_interrupt <= 1'b0;
		@(posedge clk);
		take(EXT_ONE_VECTOR);
		rchk(OFS_FLAGS, 32'h0, "flags");
		wr(OFS_CTRL, 32'hf);
		pins_u.set_req(1'b0, 1'b1);
		pins_u.set_req(1'b1, 1'b1);
		repeat (6) @(posedge clk);
		rchk(OFS_FLAGS, 32'hc0, "flags");
		wr(OFS_FLAGS, 32'h40);
		rchk(OFS_FLAGS, 32'h80, "flags");
		wr(OFS_FLAGS, 32'h80);
		wr(OFS_CTRL, 32'h5);
		pins_u.set_req(1'b1, 1'b0);
		repeat (6) @(posedge clk);
		rchk(OFS_FLAGS, 32'h80, "flags");
		wr(OFS_CTRL, 32'h0);
		pins_u.set_req(1'b0, 1'b0);
		rchk(OFS_FLAGS, 32'h0, "flags");
		wr(OFS_STATUS, 32'h80);
		wait_pend(EXT_ZERO_VECTOR);
		pins_u.set_req(1'b0, 1'b1);
		pins_u.set_req(1'b1, 1'b1);
		repeat (6) @(posedge clk);
		chk("pending", 0, pend);
		end_sim();
	end

	// Hang guard, far beyond the few hundred cycles the tests need.
	initial
	begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
